// ---- rtl/arfw_defs.svh ----
`ifndef ARFW_DEFS_SVH
`define ARFW_DEFS_SVH

// ----------------------------------------
// Register byte offsets (index times four)
// ----------------------------------------
`define ARFW_IDX_RES_LOW 8'hbe
`define ARFW_IDX_RES_HIGH 8'hbf
`define ARFW_ADDR_RES_LOW 12'h2f8
`define ARFW_ADDR_RES_HIGH 12'h2fc
`define ARFW_ADDR_UPPER_HIGH 12'h300
`define ARFW_ADDR_UPPER_LOW 12'h304
`define ARFW_ADDR_LOWER_HIGH 12'h308
`define ARFW_ADDR_LOWER_LOW 12'h30c
`define ARFW_ADDR_CTRL 12'h310
`define ARFW_ADDR_STATUS 12'h314
`define ARFW_ADDR_MASK 12'h318

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define ARFW_CTRL_LJUST 0
`define ARFW_CTRL_DIFF 1
`define ARFW_ST_WIN 0
`define ARFW_ST_DONE 1
`define ARFW_RST_BYTE 8'h00
`define ARFW_RST_LIMIT 8'hff
`define ARFW_RST_UPPER 8'h00

`endif

// ---- rtl/arfw_pkg.sv ----
package arfw_pkg;
    typedef logic [7:0] arfw_byte_t;
    typedef logic [1:0] arfw_evt_t;
    typedef enum logic [1:0] {
        ARFW_IDLE = 2'h1,
        ARFW_ACCESS = 2'h2
    } arfw_apb_state_t;
endpackage

// ---- rtl/arfw_result_if.sv ----
`timescale 1ns/1ps
// Formatted result pair passed from the formatter to the register file
interface arfw_result_if;
    logic [7:0] res_high;
    logic [7:0] res_low;
    logic valid;
    modport src (output res_high, output res_low, output valid);
    modport dst (input res_high, input res_low, input valid);
endinterface

// ---- rtl/arfw_formatter.sv ----
`timescale 1ns/1ps
`include "arfw_defs.svh"
// Registers the justified result pair one cycle after end of conversion
module arfw_formatter #(
    parameter int RES_W = 12
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic conv_done,
    input wire logic [RES_W-1:0] conv_data,
    input wire logic left_justify_select,
    input wire logic diff_mode,
    arfw_result_if.src res
);
    // ----------------------------------------
    // Justification
    // ----------------------------------------
    logic [3:0] sign_nib;
    logic [7:0] nxt_high;
    logic [7:0] nxt_low;
    assign sign_nib = diff_mode ? {4{conv_data[11]}} : 4'h0;
    assign nxt_high = left_justify_select ? conv_data[11:4]
                                          : {sign_nib, conv_data[11:8]};
    assign nxt_low = left_justify_select ? {conv_data[3:0], 4'h0}
                                         : conv_data[7:0];

    // Capture only on the done strobe so the pair holds between conversions
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            res.res_high <= `ARFW_RST_BYTE;
            res.res_low <= `ARFW_RST_BYTE;
            res.valid <= 1'b0;
        end else begin
            res.valid <= conv_done;
            if (conv_done) begin
                res.res_high <= nxt_high;
                res.res_low <= nxt_low;
            end
        end
    end
endmodule

// ---- rtl/arfw_top.sv ----
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`include "arfw_defs.svh"
// Result formatting and window compare with an APB register file
module arfw_top #(
    parameter int RES_W = 12
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic conv_done,
    input wire logic [RES_W-1:0] conv_data,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic window_compare_flag,
    output logic irq
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    arfw_pkg::arfw_byte_t upper_limit_high_byte_ff;
    arfw_pkg::arfw_byte_t upper_limit_low_byte_ff;
    arfw_pkg::arfw_byte_t lower_limit_high_byte_ff;
    arfw_pkg::arfw_byte_t lower_limit_low_byte_ff;
    arfw_pkg::arfw_byte_t res_high_ff;
    arfw_pkg::arfw_byte_t res_low_ff;
    logic [1:0] ctrl_ff;
    arfw_pkg::arfw_evt_t status_ff;
    arfw_pkg::arfw_evt_t mask_ff;
    logic cmp_pending_ff;

    arfw_result_if res_bus ();

    arfw_formatter #(
        .RES_W(RES_W)
    ) u_fmt (
        .clk_sys(clk_sys),
        .reset(reset),
        .conv_done(conv_done),
        .conv_data(conv_data),
        .left_justify_select(ctrl_ff[`ARFW_CTRL_LJUST]),
        .diff_mode(ctrl_ff[`ARFW_CTRL_DIFF]),
        .res(res_bus)
    );

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic acc;
    logic wr;
    logic hit;
    assign acc = psel & penable & ~pready;
    // Writes land at the edge where the master samples pready high, never earlier
    assign wr = psel & penable & pready & pwrite;

    function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ref_a);
        is_addr = (a == ref_a);
    endfunction

    logic w_rl;
    logic w_rh;
    logic w_uh;
    logic w_ul;
    logic w_lh;
    logic w_ll;
    logic w_ct;
    logic w_st;
    logic w_mk;
    assign w_rl = wr & is_addr(paddr, `ARFW_ADDR_RES_LOW);
    assign w_rh = wr & is_addr(paddr, `ARFW_ADDR_RES_HIGH);
    assign w_uh = wr & is_addr(paddr, `ARFW_ADDR_UPPER_HIGH);
    assign w_ul = wr & is_addr(paddr, `ARFW_ADDR_UPPER_LOW);
    assign w_lh = wr & is_addr(paddr, `ARFW_ADDR_LOWER_HIGH);
    assign w_ll = wr & is_addr(paddr, `ARFW_ADDR_LOWER_LOW);
    assign w_ct = wr & is_addr(paddr, `ARFW_ADDR_CTRL);
    assign w_st = wr & is_addr(paddr, `ARFW_ADDR_STATUS);
    assign w_mk = wr & is_addr(paddr, `ARFW_ADDR_MASK);

    // Read mux; narrow registers sit in the low bits
    logic [31:0] rd_mux;
    assign hit = is_addr(paddr, `ARFW_ADDR_RES_LOW) | is_addr(paddr, `ARFW_ADDR_RES_HIGH)
               | is_addr(paddr, `ARFW_ADDR_UPPER_HIGH) | is_addr(paddr, `ARFW_ADDR_UPPER_LOW)
               | is_addr(paddr, `ARFW_ADDR_LOWER_HIGH) | is_addr(paddr, `ARFW_ADDR_LOWER_LOW)
               | is_addr(paddr, `ARFW_ADDR_CTRL) | is_addr(paddr, `ARFW_ADDR_STATUS)
               | is_addr(paddr, `ARFW_ADDR_MASK);
    assign rd_mux = is_addr(paddr, `ARFW_ADDR_RES_LOW) ? {24'h0, res_low_ff}
                  : is_addr(paddr, `ARFW_ADDR_RES_HIGH) ? {24'h0, res_high_ff}
                  : is_addr(paddr, `ARFW_ADDR_UPPER_HIGH) ? {24'h0, upper_limit_high_byte_ff}
                  : is_addr(paddr, `ARFW_ADDR_UPPER_LOW) ? {24'h0, upper_limit_low_byte_ff}
                  : is_addr(paddr, `ARFW_ADDR_LOWER_HIGH) ? {24'h0, lower_limit_high_byte_ff}
                  : is_addr(paddr, `ARFW_ADDR_LOWER_LOW) ? {24'h0, lower_limit_low_byte_ff}
                  : is_addr(paddr, `ARFW_ADDR_CTRL) ? {30'h0, ctrl_ff}
                  : is_addr(paddr, `ARFW_ADDR_STATUS) ? {30'h0, status_ff}
                  : is_addr(paddr, `ARFW_ADDR_MASK) ? {30'h0, mask_ff}
                  : 32'h0;

    // APB answer: one wait state, pready pulses in the second access cycle
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= acc;
            pslverr <= acc & ~hit;
            prdata <= (acc & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    // ----------------------------------------
    // Limit words and control
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            upper_limit_high_byte_ff <= `ARFW_RST_UPPER;
            upper_limit_low_byte_ff <= `ARFW_RST_UPPER;
            lower_limit_high_byte_ff <= `ARFW_RST_LIMIT;
            lower_limit_low_byte_ff <= `ARFW_RST_LIMIT;
            ctrl_ff <= 2'h0;
            mask_ff <= 2'h0;
        end else begin
            if (w_uh) upper_limit_high_byte_ff <= pwdata[7:0];
            if (w_ul) upper_limit_low_byte_ff <= pwdata[7:0];
            if (w_lh) lower_limit_high_byte_ff <= pwdata[7:0];
            if (w_ll) lower_limit_low_byte_ff <= pwdata[7:0];
            if (w_ct) ctrl_ff <= pwdata[1:0];
            if (w_mk) mask_ff <= pwdata[1:0];
        end
    end

    // Result pair: converter result wins over a software write in the same cycle
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            res_high_ff <= `ARFW_RST_BYTE;
            res_low_ff <= `ARFW_RST_BYTE;
            cmp_pending_ff <= 1'b0;
        end else begin
            cmp_pending_ff <= res_bus.valid;
            if (res_bus.valid) begin
                res_high_ff <= res_bus.res_high;
                res_low_ff <= res_bus.res_low;
            end else begin
                if (w_rh) res_high_ff <= pwdata[7:0];
                if (w_rl) res_low_ff <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // Window compare
    // ----------------------------------------
    // Compare the justified pair, so limits use the same format
    logic [15:0] res_word;
    logic [15:0] gt_word;
    logic [15:0] lt_word;
    logic below_lt;
    logic above_gt;
    logic in_alarm;
    assign res_word = {res_high_ff, res_low_ff};
    assign gt_word = {upper_limit_high_byte_ff, upper_limit_low_byte_ff};
    assign lt_word = {lower_limit_high_byte_ff, lower_limit_low_byte_ff};
    assign below_lt = res_word < lt_word;
    assign above_gt = res_word > gt_word;
    assign in_alarm = (lt_word <= gt_word) ? (below_lt | above_gt)
                                           : (below_lt & above_gt);

    // Sticky events; set wins over write-one-to-clear
    arfw_pkg::arfw_evt_t evt;
    arfw_pkg::arfw_evt_t nxt_status;
    assign evt[`ARFW_ST_WIN] = cmp_pending_ff & in_alarm;
    assign evt[`ARFW_ST_DONE] = cmp_pending_ff;
    assign nxt_status = (status_ff & ~(w_st ? pwdata[1:0] : 2'h0)) | evt;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            status_ff <= 2'h0;
            window_compare_flag <= 1'b0;
            irq <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            window_compare_flag <= nxt_status[`ARFW_ST_WIN];
            irq <= |(nxt_status & mask_ff);
        end
    end
endmodule

// ---- verif/arfw_top_sva.sv ----
`timescale 1ns/1ps
`include "arfw_defs.svh"
// ------------------------------
// Checker on the top-level ports
// ------------------------------
module arfw_top_sva #(
    parameter int RES_W = 12
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic conv_done,
    input wire logic [RES_W-1:0] conv_data,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic window_compare_flag,
    input wire logic irq
);
    // Every check samples on the system clock and sleeps in reset
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    // Write of one to the window bit, the only way the flag may drop
    wire clr_win = psel && penable && pready && pwrite && paddr == `ARFW_ADDR_STATUS && pwdata[0];
    sequence setup_s;
        psel && !penable ##1 psel && penable && !pready;
    endsequence
    answer_time_a: assert property (setup_s |=> pready) else $error("No answer after access");
    ready_pulse_a: assert property (pready |=> !pready) else $error("Ready held too long");
    ready_cause_a: assert property (pready |-> $past(psel && penable)) else $error("Ready without access");
    idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("Read data outside answer");
    byte_reg_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("Upper bits set");
    err_ready_a: assert property (pslverr |-> pready) else $error("Error without ready");
    flag_hold_a: assert property ($fell(window_compare_flag) |-> $past(clr_win) || $past(clr_win, 2))
        else $error("Flag dropped without clear");
    flag_cause_a: assert property ($rose(window_compare_flag) |-> $past(conv_done, 3) || $past(conv_done, 4))
        else $error("Flag rose without conversion");
endmodule

bind arfw_top arfw_top_sva #(.RES_W(RES_W)) u_sva (
    .clk_sys, .reset, .conv_done, .conv_data, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .window_compare_flag, .irq
);

// ---- verif/arfw_conv_model.sv ----
`timescale 1ns/1ps
// -----------------------
// Converter core stand-in
// -----------------------
module arfw_conv_model (
    input wire logic clk_sys,
    input wire logic start,
    input wire logic [3:0] delay,
    input wire logic [11:0] word,
    output logic conv_done = 1'b0,
    output logic [11:0] conv_data = 12'h000
);
    // Word valid only with the strobe; else its inverse, so stale data never passes
    always @(posedge clk_sys) begin
        if (start) begin
            repeat (delay) @(posedge clk_sys);
            conv_done <= 1'b1;
            conv_data <= word;
            @(posedge clk_sys);
            conv_done <= 1'b0;
            conv_data <= ~word;
        end
    end
endmodule

// ---- verif/tb_adc_result_format_window_detect.sv ----
`timescale 1ns/1ps
`include "arfw_defs.svh"
// ----------------------------------
// Bench for result format and window
// ----------------------------------
module tb_adc_result_format_window_detect;
    typedef struct {
        logic [1:0] ctrl;
        logic [15:0] lo_lim;
        logic [15:0] hi_lim;
        logic [11:0] data;
        logic [7:0] hi;
        logic [7:0] lo;
        logic flag;
    } arfw_row_t;
    // Control, lower and upper limits, raw word, expected bytes, expected alarm
    arfw_row_t rows [12] = '{
        '{2'h0, 16'h0100, 16'h0200, 12'habc, 8'h0a, 8'hbc, 1'b1},
        '{2'h2, 16'h0100, 16'h0200, 12'h8bc, 8'hf8, 8'hbc, 1'b1},
        '{2'h2, 16'h0100, 16'h0200, 12'h150, 8'h01, 8'h50, 1'b0},
        '{2'h0, 16'h0100, 16'h0200, 12'h0ff, 8'h00, 8'hff, 1'b1},
        '{2'h0, 16'h0100, 16'h0200, 12'h201, 8'h02, 8'h01, 1'b1},
        '{2'h0, 16'h0100, 16'h0200, 12'h200, 8'h02, 8'h00, 1'b0},
        '{2'h0, 16'h0100, 16'h0200, 12'h100, 8'h01, 8'h00, 1'b0},
        '{2'h0, 16'h0200, 16'h0100, 12'h150, 8'h01, 8'h50, 1'b1},
        '{2'h0, 16'h0200, 16'h0100, 12'h250, 8'h02, 8'h50, 1'b0},
        '{2'h1, 16'h2000, 16'h1000, 12'h150, 8'h15, 8'h00, 1'b1},
        '{2'h1, 16'h0100, 16'h0200, 12'habc, 8'hab, 8'hc0, 1'b1},
        '{2'h3, 16'h0100, 16'h0200, 12'h8bc, 8'h8b, 8'hc0, 1'b1}
    };
    logic clk_sys, conv_done, pready, pslverr, window_compare_flag, irq, err;
    logic reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0;
    logic [11:0] paddr = 12'h000, word = 12'h000, conv_data;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] dly = 4'h0;
    int n_fail = 0;
    int total_checks = 0;
    arfw_top #(.RES_W(12)) uut (
        .clk_sys, .reset, .conv_done, .conv_data, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .window_compare_flag, .irq
    );
    arfw_conv_model model (.clk_sys, .start, .delay(dly), .word, .conv_done, .conv_data);
    // Free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // One transfer; request held until ready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    // Start one conversion and wait until its status has landed
    task automatic conv(input logic [11:0] w, input logic [3:0] dl);
        int n;
        @(posedge clk_sys);
        start <= 1'b1;
        word <= w;
        dly <= dl;
        @(posedge clk_sys);
        start <= 1'b0;
        for (n = 0; n < 30 && conv_done !== 1'b1; n++) @(posedge clk_sys);
        if (n == 30) begin
            n_fail++;
            tally_and_finish();
        end else begin
            repeat (3) @(posedge clk_sys);
        end
    endtask
    // Main sequence: reset values, table of conversions, then hand cases
    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        chk({window_compare_flag, irq, pready, pslverr}, 32'h0);
        apb(1'b0, `ARFW_ADDR_LOWER_LOW, 32'h0);
        chk(rd, 32'hff);
        apb(1'b0, `ARFW_ADDR_UPPER_HIGH, 32'h0);
        chk(rd, 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, `ARFW_ADDR_CTRL, {30'h0, rows[i].ctrl});
            apb(1'b1, `ARFW_ADDR_LOWER_HIGH, {24'h0, rows[i].lo_lim[15:8]});
            apb(1'b1, `ARFW_ADDR_LOWER_LOW, {24'h0, rows[i].lo_lim[7:0]});
            apb(1'b1, `ARFW_ADDR_UPPER_HIGH, {24'h0, rows[i].hi_lim[15:8]});
            apb(1'b1, `ARFW_ADDR_UPPER_LOW, {24'h0, rows[i].hi_lim[7:0]});
            apb(1'b1, `ARFW_ADDR_STATUS, 32'h3);
            conv(rows[i].data, 4'((i % 3) * 5));
            apb(1'b0, `ARFW_ADDR_RES_HIGH, 32'h0);
            chk(rd, {24'h0, rows[i].hi});
            apb(1'b0, `ARFW_ADDR_RES_LOW, 32'h0);
            chk(rd, {24'h0, rows[i].lo});
            apb(1'b0, `ARFW_ADDR_STATUS, 32'h0);
            chk(rd, {30'h0, 1'b1, rows[i].flag});
            chk(window_compare_flag, rows[i].flag);
        end
        // A quiet result after an alarm leaves the flag alone
        conv(12'h018, 4'h2);
        chk(window_compare_flag, 1'b1);
        // Unmask the window bit, then probe an unmapped place
        apb(1'b1, `ARFW_ADDR_MASK, 32'h1);
        apb(1'b0, 12'hffc, 32'h0);
        chk({rd[29:0], irq, err}, 32'h3);
        // Clearing the window bit drops flag and interrupt but keeps done
        apb(1'b1, `ARFW_ADDR_STATUS, 32'h1);
        apb(1'b0, `ARFW_ADDR_STATUS, 32'h0);
        chk({rd[29:0], irq, window_compare_flag}, 32'h8);
        tally_and_finish();
    end
endmodule
